// *** design/backlight_pkg.sv ***
package backlight_pkg;

    // Register map, internal register port addresses
    localparam logic [7:0] ADDR_SINK_EN  = 8'h10;
    localparam logic [7:0] ADDR_CFG      = 8'h20;
    localparam logic [7:0] ADDR_AMB      = 8'h50;
    localparam logic [7:0] ADDR_RES      = 8'h51;
    localparam logic [7:0] ADDR_ZB0      = 8'h60;
    localparam logic [7:0] ADDR_ZT0      = 8'h70;
    localparam logic [7:0] ADDR_BRT_MAIN = 8'ha0;
    localparam logic [7:0] ADDR_BRT_SEC  = 8'ha1;

    // Configuration bit positions
    localparam int CFG_PWM_EN   = 0;
    localparam int CFG_FLEX2    = 2;
    localparam int CFG_FLEX1    = 3;
    localparam int CFG_MAIN_AMB = 4;
    localparam int CFG_SEC_AMB  = 5;
    localparam int CFG_AMB_EN   = 6;
    localparam int AMB_AVG_LSB  = 4;

    // Reset values
    localparam logic [7:0]      SINK_EN_RST = 8'h00;
    localparam logic [7:0]      CFG_RST     = 8'h00;
    localparam logic [7:0]      AMB_RST     = 8'h00;
    localparam logic [7:0]      RES_RST     = 8'h00;
    localparam logic [6:0]      BRT_RST     = 7'h00;
    localparam logic [3:0][7:0] ZB_RST      = {8'hcc, 8'h99, 8'h66, 8'h33};
    localparam logic [4:0][6:0] ZT_RST      = {7'h7f, 7'h66, 7'h4c, 7'h33, 7'h19};

    // Timing
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned SAMPLE_HZ    = 16_000;
    localparam int unsigned SAMPLE_CYC   = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned BASE_AVG_MS  = 25;
    localparam int unsigned BASE_SAMPLES = SAMPLE_HZ * BASE_AVG_MS / 1000;
    localparam logic [7:0]  PWM_WIN_LAST = 8'hfe;
    localparam logic [7:0]  DUTY_FULL    = 8'hff;

    typedef enum logic [1:0] {
        DIR_REST = 2'b00,
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic [7:0]      sink_en;
        logic [7:0]      cfg;
        logic [7:0]      amb;
        logic [7:0]      res;
        logic [3:0][7:0] zb;
        logic [4:0][6:0] zt;
        logic [6:0]      brt_main;
        logic [6:0]      brt_sec;
        logic [15:0]     div;
        logic            tick;
        logic [15:0]     nsamp;
        logic [17:0]     sum;
        logic            avg_stb;
        logic            have_avg;
        logic [2:0]      prev_avg;
        dir_t            last_dir;
        logic [2:0]      zone;
        logic [7:0]      pwm_cnt;
        logic [7:0]      pwm_hi;
        logic [7:0]      duty;
        logic [14:0]     main_level;
        logic [14:0]     sec_level;
        logic [7:0]      sink_on;
        logic [7:0]      to_main;
        logic [7:0]      to_sec;
        logic [7:0]      rd_data;
    } state_t;

endpackage

// *** design/ambient_zone_backlight_control.sv ***
`timescale 1ns/10ps
`default_nettype none

module ambient_zone_backlight_control #(
    parameter int unsigned SAMPLE_CYC = backlight_pkg::SAMPLE_CYC
) (
    input  wire logic                    clk_sys,             // System clock, 100 MHz
    input  wire logic                    rst_b,               // Async reset, active low
    input  wire backlight_pkg::reg_wr_t  reg_wr,              // Register write strobe
    input  wire logic [7:0]              rd_addr,             // Register read address
    input  wire logic [7:0]              primary_light_input, // Digitised light level
    input  wire logic                    pwm_in,              // External PWM input
    output logic [7:0]                   rd_data,             // Read data, one cycle later
    output logic [2:0]                   zone,                // Current brightness zone
    output logic [14:0]                  main_level,          // Main group current code
    output logic [14:0]                  sec_level,           // Secondary group current code
    output logic [7:0]                   sink_on,             // Per sink enable
    output logic [7:0]                   sink_to_main,        // Sink belongs to main group
    output logic [7:0]                   sink_to_sec          // Sink belongs to secondary
);

    backlight_pkg::state_t s_q;
    backlight_pkg::state_t s_d;

    logic [2:0]       avg_sel;
    logic [2:0]       samp_zone;
    logic [17:0]      shifted;
    logic [2:0]       avg_w;
    logic [15:0]      period_n;
    backlight_pkg::dir_t dir_w;
    logic [6:0]       main_fac;
    logic [6:0]       sec_fac;
    logic [7:0]       duty_use;
    logic [3:0]       zb_hit;
    logic [2:0]       zt_idx;

    // Per-boundary compare of the current sample
    for (genvar k = 0; k < 4; k++)
    begin : g_bound
        assign zb_hit[k] = primary_light_input > s_q.zb[k];
    end

    always_comb
    begin
        s_d       = s_q;
        avg_sel   = s_q.amb[backlight_pkg::AMB_AVG_LSB +: 3];
        period_n  = 16'(backlight_pkg::BASE_SAMPLES) << avg_sel;
        samp_zone = 3'(zb_hit[0]) + 3'(zb_hit[1]) + 3'(zb_hit[2]) + 3'(zb_hit[3]);
        if (!s_q.cfg[backlight_pkg::CFG_AMB_EN])
        begin
            samp_zone = 3'h0;
        end
        // Floor of sum/(N<<sel) without a divider: shift, then compare multiples
        shifted = s_q.sum >> avg_sel;
        avg_w   = 3'h0;
        for (int m = 1; m <= 4; m++)
        begin
            if (shifted >= 18'(backlight_pkg::BASE_SAMPLES * m))
            begin
                avg_w = 3'(m);
            end
        end
        if (avg_w > s_q.prev_avg)
        begin
            dir_w = backlight_pkg::DIR_UP;
        end
        else if (avg_w < s_q.prev_avg)
        begin
            dir_w = backlight_pkg::DIR_DOWN;
        end
        else
        begin
            dir_w = backlight_pkg::DIR_REST;
        end

        // Free-running sample divider; never restarted by the input
        s_d.tick = 1'b0;
        s_d.div  = s_q.div + 16'h0001;
        if (s_q.div == 16'(SAMPLE_CYC - 1))
        begin
            s_d.div  = 16'h0000;
            s_d.tick = 1'b1;
        end

        s_d.avg_stb = 1'b0;
        if (s_q.tick)
        begin
            if (s_q.nsamp >= period_n - 16'h0001)
            begin
                // Period end: average this sample in, emit, restart window
                s_d.nsamp    = 16'h0000;
                s_d.sum      = s_q.sum + 18'(samp_zone);
                s_d.avg_stb  = 1'b1;
            end
            else
            begin
                s_d.nsamp = s_q.nsamp + 16'h0001;
                s_d.sum   = s_q.sum + 18'(samp_zone);
            end
        end
        if (s_q.avg_stb)
        begin
            s_d.sum = 18'h00000;
        end

        // Discriminator on the three most recent averages
        // A confirmed step may only move the zone the way the history points
        if (s_q.avg_stb)
        begin
            s_d.have_avg = 1'b1;
            s_d.prev_avg = avg_w;
            s_d.last_dir = dir_w;
            unique case (s_q.last_dir)
                backlight_pkg::DIR_UP:
                begin
                    if (dir_w != backlight_pkg::DIR_DOWN && avg_w >= s_q.zone)
                    begin
                        s_d.zone = avg_w;
                    end
                end
                backlight_pkg::DIR_DOWN:
                begin
                    if (dir_w != backlight_pkg::DIR_UP && avg_w <= s_q.zone)
                    begin
                        s_d.zone = avg_w;
                    end
                end
                default:
                begin
                    s_d.zone = s_q.zone;
                end
            endcase
        end

        // PWM duty measured over a fixed window of 255 cycles
        s_d.pwm_cnt = s_q.pwm_cnt + 8'h01;
        s_d.pwm_hi  = s_q.pwm_hi + 8'(pwm_in);
        if (s_q.pwm_cnt == backlight_pkg::PWM_WIN_LAST)
        begin
            s_d.pwm_cnt = 8'h00;
            s_d.pwm_hi  = 8'h00;
            s_d.duty    = s_q.pwm_hi + 8'(pwm_in);
        end

        // Current codes; the zone index stays in 0..4 by construction
        zt_idx   = (s_q.zone > 3'h4) ? 3'h4 : s_q.zone;
        main_fac = s_q.cfg[backlight_pkg::CFG_MAIN_AMB] ? s_q.zt[zt_idx] : s_q.brt_main;
        sec_fac  = s_q.cfg[backlight_pkg::CFG_SEC_AMB] ? s_q.zt[zt_idx] : s_q.brt_sec;
        duty_use = s_q.cfg[backlight_pkg::CFG_PWM_EN] ? s_q.duty : backlight_pkg::DUTY_FULL;
        s_d.main_level = 15'(main_fac * duty_use);
        s_d.sec_level  = 15'(sec_fac * duty_use);

        // Sinks 0-3 fixed main, 4/5 flexible, 6 secondary, 7 third group
        s_d.sink_on = s_q.sink_en;
        s_d.to_main = {2'b00, s_q.cfg[backlight_pkg::CFG_FLEX2],
                       s_q.cfg[backlight_pkg::CFG_FLEX1], 4'hf};
        s_d.to_sec  = {2'b01, ~s_q.cfg[backlight_pkg::CFG_FLEX2],
                       ~s_q.cfg[backlight_pkg::CFG_FLEX1], 4'h0};

        // Register writes
        if (reg_wr.en)
        begin
            case (reg_wr.addr)
                backlight_pkg::ADDR_SINK_EN:  s_d.sink_en  = reg_wr.data;
                backlight_pkg::ADDR_CFG:      s_d.cfg      = reg_wr.data;
                backlight_pkg::ADDR_AMB:      s_d.amb      = reg_wr.data;
                backlight_pkg::ADDR_RES:      s_d.res      = reg_wr.data;
                backlight_pkg::ADDR_BRT_MAIN: s_d.brt_main = reg_wr.data[6:0];
                backlight_pkg::ADDR_BRT_SEC:  s_d.brt_sec  = reg_wr.data[6:0];
                default:
                begin
                    if (reg_wr.addr[7:2] == backlight_pkg::ADDR_ZB0[7:2])
                    begin
                        s_d.zb[reg_wr.addr[1:0]] = reg_wr.data;
                    end
                    else if (reg_wr.addr >= backlight_pkg::ADDR_ZT0 &&
                             reg_wr.addr <= backlight_pkg::ADDR_ZT0 + 8'h04)
                    begin
                        s_d.zt[3'(reg_wr.addr - backlight_pkg::ADDR_ZT0)] = reg_wr.data[6:0];
                    end
                end
            endcase
        end

        // Register reads; unmapped addresses read zero, targets read top bit set
        case (rd_addr)
            backlight_pkg::ADDR_SINK_EN:  s_d.rd_data = s_q.sink_en;
            backlight_pkg::ADDR_CFG:      s_d.rd_data = s_q.cfg;
            backlight_pkg::ADDR_AMB:      s_d.rd_data = s_q.amb;
            backlight_pkg::ADDR_RES:      s_d.rd_data = s_q.res;
            backlight_pkg::ADDR_BRT_MAIN: s_d.rd_data = {1'b0, s_q.brt_main};
            backlight_pkg::ADDR_BRT_SEC:  s_d.rd_data = {1'b0, s_q.brt_sec};
            default:
            begin
                s_d.rd_data = 8'h00;
                if (rd_addr[7:2] == backlight_pkg::ADDR_ZB0[7:2])
                begin
                    s_d.rd_data = s_q.zb[rd_addr[1:0]];
                end
                else if (rd_addr >= backlight_pkg::ADDR_ZT0 &&
                         rd_addr <= backlight_pkg::ADDR_ZT0 + 8'h04)
                begin
                    s_d.rd_data = {1'b1, s_q.zt[3'(rd_addr - backlight_pkg::ADDR_ZT0)]};
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q          <= '0;
            s_q.sink_en  <= backlight_pkg::SINK_EN_RST;
            s_q.cfg      <= backlight_pkg::CFG_RST;
            s_q.amb      <= backlight_pkg::AMB_RST;
            s_q.res      <= backlight_pkg::RES_RST;
            s_q.zb       <= backlight_pkg::ZB_RST;
            s_q.zt       <= backlight_pkg::ZT_RST;
            s_q.brt_main <= backlight_pkg::BRT_RST;
            s_q.brt_sec  <= backlight_pkg::BRT_RST;
            s_q.prev_avg <= 3'h0;
            s_q.last_dir <= backlight_pkg::DIR_REST;
            s_q.to_main  <= 8'h0f;
            s_q.to_sec   <= 8'h70;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data      = s_q.rd_data;
    assign zone         = s_q.zone;
    assign main_level   = s_q.main_level;
    assign sec_level    = s_q.sec_level;
    assign sink_on      = s_q.sink_on;
    assign sink_to_main = s_q.to_main;
    assign sink_to_sec  = s_q.to_sec;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sample_rate_a: assert property (s_q.tick |-> $past(s_q.div) == 16'(SAMPLE_CYC - 1))
        else $error("sample tick off the divider period");
    avg_emit_a: assert property (s_q.avg_stb |-> s_q.nsamp == 16'h0000 && $past(s_q.tick))
        else $error("average emitted off a period end");
    start_zero_a: assert property (!s_q.have_avg |-> s_q.prev_avg == 3'h0 && s_q.zone == 3'h0)
        else $error("previous result not zone zero before first average");
    truncate_a: assert property (s_q.avg_stb |->
        32'(avg_w) * 32'(period_n) <= 32'(s_q.sum) &&
        (avg_w == 3'h4 || 32'(s_q.sum) < (32'(avg_w) + 1) * 32'(period_n)))
        else $error("averaged zone not truncated");
    hold_zone_a: assert property (s_q.avg_stb && s_q.last_dir == backlight_pkg::DIR_REST
        |=> $stable(s_q.zone))
        else $error("zone moved after a single step");
    up_move_a: assert property (s_q.avg_stb ##1 s_q.zone > $past(s_q.zone) |->
        $past(s_q.last_dir) == backlight_pkg::DIR_UP)
        else $error("zone rose without a prior increase");
    down_move_a: assert property (s_q.avg_stb ##1 s_q.zone < $past(s_q.zone) |->
        $past(s_q.last_dir) == backlight_pkg::DIR_DOWN)
        else $error("zone fell without a prior decrease");
    two_step_a: assert property (s_q.avg_stb && s_q.last_dir != backlight_pkg::DIR_REST &&
        dir_w == s_q.last_dir &&
        ((dir_w == backlight_pkg::DIR_UP) == (avg_w >= s_q.zone)) |=> s_q.zone == $past(avg_w))
        else $error("two steps did not reach latest average");
    level_calc_a: assert property (##1 s_q.main_level ==
        15'($past(main_fac) * ($past(s_q.cfg[backlight_pkg::CFG_PWM_EN]) ?
        $past(s_q.duty) : backlight_pkg::DUTY_FULL)))
        else $error("main level not factor times duty");
    third_group_a: assert property (!s_q.to_main[7] && !s_q.to_sec[7] &&
        s_q.to_main[3:0] == 4'hf && s_q.to_sec[6])
        else $error("fixed sink left its group");
    flex_map_a: assert property (##1 s_q.to_main[5:4] ==
        {$past(s_q.cfg[backlight_pkg::CFG_FLEX2]), $past(s_q.cfg[backlight_pkg::CFG_FLEX1])} &&
        s_q.to_sec[5:4] == ~s_q.to_main[5:4])
        else $error("flexible sink assignment mismatch");

endmodule

`default_nettype wire

// *** tb/light_sensor_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module light_sensor_model (
    input  wire logic       clk_sys, // System clock
    input  wire logic [7:0] level,   // Commanded light level
    input  wire logic [7:0] duty,    // Commanded high cycles per 255
    output var logic  [7:0] light,   // Digitised light sample
    output var logic        pwm      // PWM waveform
);
    logic [7:0] cnt_q;

    initial
    begin
        cnt_q = 8'h00;
        light = 8'h00;
        pwm   = 1'b0;
    end

    // A period of 255 keeps the high count in any 255 cycle window exact
    always @(posedge clk_sys)
    begin
        cnt_q <= (cnt_q == 8'hfe) ? 8'h00 : cnt_q + 8'h01;
        pwm   <= cnt_q < duty;
        light <= level;
    end
endmodule

`default_nettype wire

// *** tb/ambient_zone_backlight_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module ambient_zone_backlight_control_test;
    localparam int SC   = 4;
    localparam int PER  = 400 * SC;
    localparam int CEIL = 95000;

    logic                   clk_sys = 1'b0;
    logic                   rst_b   = 1'b0;
    backlight_pkg::reg_wr_t reg_wr  = '0;
    logic [7:0]             rd_addr = 8'h00;
    logic [7:0]             level   = 8'h00;
    logic [7:0]             duty    = 8'h00;
    logic [7:0]             light, rd_data, sink_on, sink_to_main, sink_to_sec, rv, a, e;
    logic                   pwm_in;
    logic [2:0]             zone;
    logic [14:0]            main_level, sec_level;
    int                     failures = 0;
    int                     checks   = 0;
    int                     cyc      = 0;
    int                     seed     = 77;
    int                     zb[4], zt[5], dl[3], tbl[5];
    int                     ez, nz, l, bm, bs, n;

    always #5 clk_sys = ~clk_sys;

    ambient_zone_backlight_control #(.SAMPLE_CYC(SC)) i_ambient_zone_backlight_control (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .rd_addr(rd_addr),
        .primary_light_input(light), .pwm_in(pwm_in), .rd_data(rd_data), .zone(zone),
        .main_level(main_level), .sec_level(sec_level), .sink_on(sink_on),
        .sink_to_main(sink_to_main), .sink_to_sec(sink_to_sec));

    light_sensor_model i_light_sensor_model (
        .clk_sys(clk_sys), .level(level), .duty(duty), .light(light), .pwm(pwm_in));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= {1'b1, ad, d};
        @(posedge clk_sys);
        reg_wr.en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk_sys);
        rd_addr <= ad;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = rd_data;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    function automatic int zone_of(input int lv);
        int c = 0;
        for (int i = 0; i < 4; i++)
            if (lv > zb[i]) c++;
        return c;
    endfunction

    task automatic complete_run;
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard sized for six zone walks of up to six periods each
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            failures++;
            complete_run();
        end
    end

    initial
    begin
        for (int i = 0; i < 4; i++) zb[i] = backlight_pkg::ZB_RST[i];
        for (int i = 0; i < 5; i++) zt[i] = backlight_pkg::ZT_RST[i];
        tbl = '{8'h66, 8'hcd, 8'h00, 8'h9a, 8'h33};
        dl  = '{0, 128, 255};
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("to_main", 16'(sink_to_main), 16'h000f);
        chk("to_sec", 16'(sink_to_sec), 16'h0070);
        chk("zone", 16'(zone), 16'h0000);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            a = (i < 4) ? 8'h60 + 8'(i) : (i < 9) ? 8'h6c + 8'(i) : 8'h55;
            e = (i < 4) ? 8'(zb[i]) : (i < 9) ? 8'h80 | 8'(zt[i - 4]) : 8'h00;
            if (i > 9) a = (i == 10) ? 8'h10 : (i == 11) ? 8'h20 : (i == 12) ? 8'h50 : 8'h51;
            rd(a, rv);
            chk("reset read", 16'(rv), 16'(e));
        end
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 8'h10 : (i == 1) ? 8'h51 : 8'h50;
            e = (i == 3) ? 8'h40 : 8'($random(seed));
            wr(a, e);
            rd(a, rv);
            chk("readback", 16'(rv), 16'(e));
        end
        wr(8'h50, 8'h00);
        wr(8'h10, 8'h3f);
        settle();
        chk("sink_on", 16'(sink_on), 16'h003f);
        for (int f = 0; f < 4; f++)
        begin
            wr(8'h20, 8'h40 | 8'(f << 2));
            settle();
            chk("to_main", 16'(sink_to_main),
                16'(8'h0f | (f[1] ? 8'h10 : 8'h00) | (f[0] ? 8'h20 : 8'h00)));
            chk("to_sec", 16'(sink_to_sec),
                16'(8'h40 | (f[1] ? 8'h00 : 8'h10) | (f[0] ? 8'h00 : 8'h20)));
        end
        bm = $random(seed) & 127;
        bs = $random(seed) & 127;
        wr(8'ha0, 8'(bm));
        wr(8'ha1, 8'(bs));
        settle();
        chk("main bank", 16'(main_level), 16'(bm * 255));
        chk("sec bank", 16'(sec_level), 16'(bs * 255));
        // Sensing runs three periods before main ambient control is switched on
        repeat (3 * PER) @(posedge clk_sys);
        wr(8'h20, 8'hdc);
        settle();
        chk("to_main", 16'(sink_to_main), 16'h003f);
        chk("to_sec", 16'(sink_to_sec), 16'h0040);
        ez = 0;
        for (int i = 0; i < 6; i++)
        begin
            l = (i < 5) ? tbl[i] : $random(seed) & 255;
            nz = zone_of(l);
            @(posedge clk_sys);
            level <= 8'(l);
            if (nz != ez)
            begin
                repeat (PER - 4) @(posedge clk_sys);
                @(negedge clk_sys);
                chk("early zone", 16'(zone), 16'(ez));
            end
            for (n = 0; n < 5 * PER && zone !== 3'(nz); n++) @(negedge clk_sys);
            chk("zone", 16'(zone), 16'(nz));
            settle();
            chk("main zone", 16'(main_level), 16'(zt[nz] * 255));
            ez = nz;
            // Let a repeat result clear the direction history before the next step
            repeat (2 * PER) @(posedge clk_sys);
        end
        wr(8'h20, 8'hfc);
        settle();
        chk("sec zone", 16'(sec_level), 16'(zt[ez] * 255));
        for (int i = 0; i < 3; i++)
        begin
            duty <= 8'(dl[i]);
            wr(8'h20, 8'hfd);
            repeat (520) @(posedge clk_sys);
            settle();
            chk("main pwm", 16'(main_level), 16'(zt[ez] * dl[i]));
            chk("sec pwm", 16'(sec_level), 16'(zt[ez] * dl[i]));
        end
        complete_run();
    end
endmodule

`default_nettype wire
